// >>> ppmc_top.sv
/*
  Port 2 / port 3 pin mode control: four mode SFRs and the pin drivers.
  Assumes the core presents one SFR access per cycle, synchronous to mclk,
  and supplies port latches, external memory address and strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module ppmc_top
  import ppmc_pkg::*;
#(
  parameter int PINS = 8
)(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire ppmc_sfr_s       sfr,
  output var  logic [7:0]      sfr_rdata,
  output var  logic            sfr_hit,
  input  wire logic            external_access_input,
  input  wire logic            port2_external_memory_select,
  input  wire logic            memory_access_control_bit1,
  input  wire logic [PINS-1:0] p2_latch,
  input  wire logic [PINS-1:0] p3_latch,
  input  wire logic [PINS-1:0] ext_addr_high,
  input  wire logic            ext_rd_n,
  input  wire logic            ext_wr_n,
  input  wire logic [PINS-1:0] p2_in,
  input  wire logic [PINS-1:0] p3_in,
  output var  logic [PINS-1:0] p2_out,
  output var  logic [PINS-1:0] p2_oe,
  output var  logic [PINS-1:0] p2_weak_pullup,
  output var  logic [PINS-1:0] p3_out,
  output var  logic [PINS-1:0] p3_oe,
  output var  logic [PINS-1:0] p3_weak_pullup,
  output var  logic [PINS-1:0] p2_pin_level,
  output var  logic [PINS-1:0] p3_pin_level
);

  logic [7:0] port2_low_pin_mode;
  logic [7:0] port2_high_pin_mode;
  logic [7:0] port3_low_pin_mode;
  logic [7:0] port3_high_pin_mode;
  logic       p2_ext;
  logic       p3_ext;

  // Field for pin n out of the low/high register pair
  // field lookup
  function automatic ppmc_mode_e pin_mode(input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input int         n);
    logic [15:0] both;
    both = {hi, lo};
    pin_mode = ppmc_mode_e'(both[n*PPMC_FIELD_W +: PPMC_FIELD_W]);
  endfunction

  // Select of each register
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, PPMC_P2_LOW_ADDR) || hit(a, PPMC_P2_HIGH_ADDR) ||
             hit(a, PPMC_P3_LOW_ADDR) || hit(a, PPMC_P3_HIGH_ADDR);
  endfunction

  // pad enable: push-pull always, pull-up and drain only low
  function automatic logic pad_oe(input ppmc_mode_e m, input logic latch);
    pad_oe = (m == PPMC_PUSHPULL) || ((m != PPMC_INPUT) && !latch);
  endfunction

  // pad data: only push-pull ever drives a high
  function automatic logic pad_out(input ppmc_mode_e m, input logic latch);
    pad_out = (m == PPMC_PUSHPULL) ? latch : 1'b0;
  endfunction

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      port2_low_pin_mode  <= PPMC_MODE_RESET;
      port2_high_pin_mode <= PPMC_MODE_RESET;
      port3_low_pin_mode  <= PPMC_MODE_RESET;
      port3_high_pin_mode <= PPMC_MODE_RESET;
    end
    else if (sfr.wr)
    begin
      if (hit(sfr.addr, PPMC_P2_LOW_ADDR))
        port2_low_pin_mode <= sfr.wdata;
      if (hit(sfr.addr, PPMC_P2_HIGH_ADDR))
        port2_high_pin_mode <= sfr.wdata;
      if (hit(sfr.addr, PPMC_P3_LOW_ADDR))
        port3_low_pin_mode <= sfr.wdata;
      if (hit(sfr.addr, PPMC_P3_HIGH_ADDR))
        port3_high_pin_mode <= sfr.wdata;
    end
  end

  // Same-cycle write and read returns the old value
  // registered readback
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end
    else
    begin
      sfr_hit <= sfr.rd && mapped(sfr.addr);
      if (!sfr.rd)
        sfr_rdata <= 8'h00;
      else if (hit(sfr.addr, PPMC_P2_LOW_ADDR))
        sfr_rdata <= port2_low_pin_mode;
      else if (hit(sfr.addr, PPMC_P2_HIGH_ADDR))
        sfr_rdata <= port2_high_pin_mode;
      else if (hit(sfr.addr, PPMC_P3_LOW_ADDR))
        sfr_rdata <= port3_low_pin_mode;
      else if (hit(sfr.addr, PPMC_P3_HIGH_ADDR))
        sfr_rdata <= port3_high_pin_mode;
      else
        sfr_rdata <= 8'h00;
    end
  end

  // override: external fetch (access input low) or select bits
  assign p2_ext = !external_access_input || port2_external_memory_select;
  assign p3_ext = !external_access_input || memory_access_control_bit1 ||
                  port2_external_memory_select;

  generate
    for (genvar i = 0; i < PINS; i++)
    begin : g_pin
      ppmc_mode_e m2;
      ppmc_mode_e m3;
      logic       s3;
      logic       strobe;
      assign m2 = pin_mode(port2_low_pin_mode, port2_high_pin_mode, i);
      assign m3 = pin_mode(port3_low_pin_mode, port3_high_pin_mode, i);
      assign s3 = (i == PPMC_P3_RD_PIN) || (i == PPMC_P3_WR_PIN);
      assign strobe = (i == PPMC_P3_RD_PIN) ? ext_rd_n : ext_wr_n;

      // port 2 driver, address bus when external
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          p2_out[i]         <= 1'b1;
          p2_oe[i]          <= 1'b0;
          p2_weak_pullup[i] <= 1'b1;
        end
        else if (p2_ext)
        begin
          p2_out[i]         <= ext_addr_high[i];
          p2_oe[i]          <= 1'b1;
          p2_weak_pullup[i] <= 1'b0;
        end
        else
        begin
          p2_out[i]         <= pad_out(m2, p2_latch[i]);
          p2_oe[i]          <= pad_oe(m2, p2_latch[i]);
          p2_weak_pullup[i] <= (m2 == PPMC_PULLUP);
        end
      end

      // Strobes win over latch and mode on pins 7 and 6 only
      // port 3 driver, strobes when external
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          p3_out[i]         <= 1'b1;
          p3_oe[i]          <= 1'b0;
          p3_weak_pullup[i] <= 1'b1;
        end
        else if (p3_ext && s3)
        begin
          p3_out[i]         <= strobe;
          p3_oe[i]          <= 1'b1;
          p3_weak_pullup[i] <= 1'b0;
        end
        else
        begin
          p3_out[i]         <= pad_out(m3, p3_latch[i]);
          p3_oe[i]          <= pad_oe(m3, p3_latch[i]);
          p3_weak_pullup[i] <= (m3 == PPMC_PULLUP);
        end
      end
    end
  endgenerate

  // Pin level seen by the core, one cycle late
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      p2_pin_level <= '1;
      p3_pin_level <= '1;
    end
    else
    begin
      p2_pin_level <= p2_in;
      p3_pin_level <= p3_in;
    end
  end

endmodule
`default_nettype wire

// >>> ppmc_pkg.sv
/*
  Package for the port pin mode control block: SFR offsets, field layout,
  reset values, mode encoding and the core-side access struct.
  Assumes an 8-bit SFR space addressed by the core.
*/
`default_nettype none
package ppmc_pkg;
  localparam logic [7:0] PPMC_P2_LOW_ADDR  = 8'hB1;
  localparam logic [7:0] PPMC_P2_HIGH_ADDR = 8'hB2;
  localparam logic [7:0] PPMC_P3_LOW_ADDR  = 8'hB3;
  localparam logic [7:0] PPMC_P3_HIGH_ADDR = 8'hB4;
  localparam logic [7:0] PPMC_MODE_RESET   = 8'h00;
  localparam int         PPMC_FIELD_W      = 2;
  localparam int         PPMC_P3_WR_PIN    = 6;
  localparam int         PPMC_P3_RD_PIN    = 7;

  typedef enum logic [1:0] {
    PPMC_PULLUP    = 2'h0,
    PPMC_PUSHPULL  = 2'h1,
    PPMC_OPENDRAIN = 2'h2,
    PPMC_INPUT     = 2'h3
  } ppmc_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppmc_sfr_s;
endpackage
`default_nettype wire

// >>> ppmc_pads_model.sv
/* Pad partner model: external circuit on eight port pins.
   Assumes the block's pad controls are stable after each mclk edge. */
`timescale 1ns/1ns
`default_nettype none
module ppmc_pads (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] drv,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] lvl
);
  // pad level resolve
  // A released line with no external drive and no pull-up shows the inverse, so a stale value never passes
  assign lvl = (oe & drv) | (~oe & ext_en & ext_val)
             | (~oe & ~ext_en & (pu | ~drv));
endmodule
`default_nettype wire

// >>> ppmc_properties.sv
/* Checker for the pin mode block.
   Assumes single clock mclk and async active-high rst. */
`timescale 1ns/1ns
`default_nettype none
module ppmc_properties
  import ppmc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire ppmc_sfr_s  sfr,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  input wire logic       external_access_input,
  input wire logic       memory_access_control_bit1,
  input wire logic [7:0] p3_latch,
  input wire logic [7:0] ext_addr_high,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p2_oe,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe
);
  logic [7:0] m3;
  logic       ok;
  assign ok = sfr.addr inside {[PPMC_P2_LOW_ADDR:PPMC_P3_HIGH_ADDR]};
  // Shadow of port 3 low modes
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      m3 <= PPMC_MODE_RESET;
    else if (sfr.wr && sfr.addr == PPMC_P3_LOW_ADDR)
      m3 <= sfr.wdata;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_HIT: assert property (sfr.rd && ok |=> sfr_hit)
    else $error("read hit missing");
  AST_MISS: assert property (sfr.rd && !ok |=> !sfr_hit && !sfr_rdata)
    else $error("unmapped read answered");
  AST_WR_RD: assert property ((sfr.wr && ok)
    ##1 (sfr.rd && sfr.addr == $past(sfr.addr))
    |=> sfr_rdata == $past(sfr.wdata, 2)) else $error("readback wrong");
  AST_PP: assert property (m3[1:0] == PPMC_PUSHPULL
    |=> p3_oe[0] && p3_out[0] == $past(p3_latch[0])) else $error("push-pull");
  AST_OD: assert property (m3[1:0] == PPMC_OPENDRAIN
    |=> p3_oe[0] == !$past(p3_latch[0]) && !p3_out[0]) else $error("drain");
  AST_IN: assert property (m3[1:0] == PPMC_INPUT |=> !p3_oe[0])
    else $error("input pin driven");
  AST_P2_OVR: assert property (!external_access_input
    |=> p2_oe == 8'hFF && p2_out == $past(ext_addr_high))
    else $error("port 2 not overridden");
  AST_P3_STRB: assert property (memory_access_control_bit1
    |=> p3_oe[7:6] == 2'h3) else $error("strobes not driven");
endmodule
bind ppmc_top ppmc_properties u_props (
  .mclk                       (mclk),
  .rst                        (rst),
  .sfr                        (sfr),
  .sfr_rdata                  (sfr_rdata),
  .sfr_hit                    (sfr_hit),
  .external_access_input      (external_access_input),
  .memory_access_control_bit1 (memory_access_control_bit1),
  .p3_latch                   (p3_latch),
  .ext_addr_high              (ext_addr_high),
  .p2_out                     (p2_out),
  .p2_oe                      (p2_oe),
  .p3_out                     (p3_out),
  .p3_oe                      (p3_oe)
);
`default_nettype wire

// >>> tb_top.sv
/* Testbench for the pin mode block: SFR tasks, mode and override tests.
   Assumes the pad partner model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ppmc_pkg::*;
  logic       mclk, rst, external_access_input, sfr_hit;
  logic       port2_external_memory_select, memory_access_control_bit1;
  logic       ext_rd_n, ext_wr_n;
  ppmc_sfr_s  sfr;
  logic [7:0] sfr_rdata, p2_latch, p3_latch, ext_addr_high, p2_in, p3_in;
  logic [7:0] p2_out, p2_oe, p2_weak_pullup, p3_out, p3_oe, x, oe;
  logic [7:0] p3_weak_pullup, p2_pin_level, p3_pin_level;
  int         err_total, n_compared;
  ppmc_top dut (.*);
  ppmc_pads u2 (.oe(p2_oe), .drv(p2_out), .pu(p2_weak_pullup),
                .ext_en(8'hFF), .ext_val(x), .lvl(p2_in));
  ppmc_pads u3 (.oe(p3_oe), .drv(p3_out), .pu(p3_weak_pullup),
                .ext_en(8'hFF), .ext_val(x), .lvl(p3_in));
  task automatic acc(input logic w, input logic [7:0] a, d);
    sfr = '{w, !w, a, d};
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(1'b0, a, 8'h00);
    chk("read", {7'h00, a inside {[8'hB1:8'hB4]}, e},
        {7'h00, sfr_hit, sfr_rdata});
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  initial
  begin
    #200000;
    err_total++;
    stop_test;
  end
  initial
  begin
    {rst, external_access_input, port2_external_memory_select} = 3'b110;
    {memory_access_control_bit1, ext_rd_n, ext_wr_n} = 3'b001;
    {p2_latch, p3_latch, ext_addr_high, x} = 32'hFF0FA55A;
    sfr = '0;
    {err_total, n_compared} = '0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int a = 8'hB1; a < 8'hB6; a++) rd(a[7:0], 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, PPMC_P2_LOW_ADDR + i[7:0], 8'h1B << i);
      rd(PPMC_P2_LOW_ADDR + i[7:0], 8'h1B << i);
    end
    $display("register test done");
    for (int m = 0; m < 4; m++)
    begin
      for (int i = 0; i < 4; i++)
        acc(1'b1, PPMC_P2_LOW_ADDR + i[7:0], 8'h55 * m[7:0]);
      repeat (2) acc(1'b0, 8'h00, 8'h00);
      oe = (m == 1) ? 8'hFF : (m == 3) ? 8'h00 : ~p3_latch;
      chk("p3 pads", {oe, (m == 1) ? p3_latch : 8'h00},
          {p3_oe, p3_out & p3_oe});
      chk("p3 level", {8'h00, (oe & p3_latch) | (~oe & x)},
          {8'h00, p3_pin_level});
      chk("p2 pads", {{8{m == 1}}, (m == 1) ? 8'hFF : x},
          {p2_oe, p2_pin_level});
      chk("pullups", {16{m == 0}}, {p2_weak_pullup, p3_weak_pullup});
    end
    $display("mode test done");
    for (int k = 0; k < 3; k++)
    begin
      {external_access_input, port2_external_memory_select} = {k != 0, k == 1};
      {memory_access_control_bit1, ext_rd_n, ext_wr_n} = {k == 2, k[0], !k[0]};
      repeat (2) acc(1'b0, 8'h00, 8'h00);
      chk("p2 override", (k < 2) ? {8'hFF, ext_addr_high} : 16'h0000,
          {p2_oe, p2_out & p2_oe});
      chk("p3 strobes", {8'hC0, ext_rd_n, ext_wr_n, 6'h00},
          {p3_oe, p3_out & p3_oe});
    end
    $display("override test done");
    memory_access_control_bit1 = 1'b0;
    rst = 1'b1;
    acc(1'b0, 8'h00, 8'h00);
    chk("reset p2 pads", 16'h00FF, {p2_oe, p2_weak_pullup});
    chk("reset p3 pads", 16'h00FF, {p3_oe, p3_weak_pullup});
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
      rd(PPMC_P2_LOW_ADDR + i[7:0], 8'h00);
    chk("reset pullups", 16'hFFFF, {p2_weak_pullup, p3_weak_pullup});
    $display("second reset test done");
    stop_test;
  end
endmodule
`default_nettype wire
